// [bench/asq_core_model.sv]
// behavioural analog core: one conv_done per conv_start
// assumes ref_clk shared with the sequencer; lat sets answer delay
module asq_core_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // sequencer side
    input wire logic conv_start,
    input wire logic [2:0] conv_channel,
    input wire logic [3:0] lat,
    output logic conv_done,
    output logic [9:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_ff;
    logic [2:0] ch_ff;
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= 4'h0;
            ch_ff <= 3'h0;
            conv_done <= 1'b0;
            conv_data <= 10'h3FF;
        end else begin
            conv_done <= 1'b0;
            // data only valid with done; toggled otherwise
            conv_data <= ~conv_data;
            if (conv_start) begin
                cnt_ff <= lat;
                ch_ff <= conv_channel;
            end else if (cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
                if (cnt_ff == 4'h1) begin
                    conv_done <= 1'b1;
                    conv_data <= {7'h5A, ch_ff};
                end
            end
        end
    end
endmodule

// [bench/asq_sequencer_props.sv]
// port assertions for the serial converter sequencer
// assumes one ref_clk domain, async active-high reset
`include "asq_defs.vh"
module asq_seq_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // pins
    input wire logic cs_n,
    input wire logic serial_out_oe,
    input wire logic done_int_n,
    // core side
    input wire logic conv_start,
    input wire logic [2:0] conv_channel,
    input wire logic conv_done,
    // status
    input wire logic [`ASQ_CFG_W-1:0] config_register,
    input wire logic [3:0] fifo_level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [1:0] mode;
    logic [3:0] thr;
    assign mode = config_register[1:0];
    assign thr = 4'h8 - {1'b0, config_register[5:4], 1'b0};
    a_start_one_clk: assert property
        (conv_start |=> !conv_start) else $error("start pulse too long");
    a_level_max: assert property
        (fifo_level <= 4'h8) else $error("fifo level above depth");
    a_push_counts: assert property
        (conv_done && fifo_level < thr |=>
         fifo_level == $past(fifo_level) + 4'h1) else $error("push lost");
    a_int_at_thr: assert property
        ($fell(done_int_n) && mode != 2'h0 |-> fifo_level == thr)
        else $error("interrupt away from threshold");
    a_eoc_busy: assert property
        (conv_start && mode == 2'h0 && config_register[3] |->
         ##[1:2] !done_int_n) else $error("end flag not low");
    a_oe_off_cs: assert property
        (cs_n [*5] |-> !serial_out_oe) else $error("driven while idle");
    a_chan_start: assert property
        ($changed(conv_channel) |-> conv_start)
        else $error("channel moved without start");
    a_level_drop: assert property
        (fifo_level < $past(fifo_level) |-> fifo_level == 4'h0 ||
         fifo_level == $past(fifo_level) - 4'h1) else $error("bad drop");
    a_cfg_clears: assert property
        ($changed(config_register) |-> fifo_level == 4'h0 ##0
         (!conv_start) [*3]) else $error("config write not quiet");
    a_cfg_no_int: assert property
        ($changed(config_register) |-> $stable(done_int_n) [*2])
        else $error("config write moved done flag");
endmodule
bind asq_sequencer asq_seq_props u_props (.ref_clk, .reset, .cs_n,
    .serial_out_oe, .done_int_n, .conv_start, .conv_channel, .conv_done,
    .config_register, .fifo_level);

// [bench/tb_adc_serial_sequencer.sv]
// self-checking bench for the serial converter sequencer
// assumes checker and core model compiled first
module tb_adc_serial_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, reset = 1'b1, cs_n = 1'b1, frame_sync = 1'b1;
    logic sclk = 1'b0, serial_in = 1'b0, start_n = 1'b1;
    logic serial_out, serial_out_oe, done_int_n, conv_start, conv_done;
    logic [2:0] conv_channel;
    logic [9:0] conv_data;
    logic [11:0] config_register;
    logic [3:0] fifo_level, lat = 4'h4;
    logic [15:0] r = 16'h0000;
    int fails = 0, total_checks = 0, starts = 0, s0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (conv_start === 1'b1) starts++;
    asq_sequencer uut (.ref_clk(ref_clk), .reset(reset), .cs_n(cs_n),
        .frame_sync(frame_sync), .sclk(sclk), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .sample_start_pin_n(start_n), .done_int_n(done_int_n),
        .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_done(conv_done), .conv_data(conv_data),
        .config_register(config_register), .fifo_level(fifo_level));
    asq_core_model core (.ref_clk(ref_clk), .reset(reset),
        .conv_start(conv_start), .conv_channel(conv_channel), .lat(lat),
        .conv_done(conv_done), .conv_data(conv_data));
    task cy(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // sclk is sampled, so each phase spans four ref_clk edges
    task frame(input logic [15:0] w);
        for (int i = 0; i < 16; i++) begin
            serial_in = w[15 - i];
            cy(4);
            r = {r[14:0], serial_out};
            sclk = 1'b1;
            cy(4);
            sclk = 1'b0;
        end
    endtask
    task xfer(input logic [15:0] w);
        cs_n = 1'b0;
        cy(4);
        frame(w);
        cy(4);
        cs_n = 1'b1;
        cy(8);
    endtask
    task pin;
        start_n = 1'b0;
        cy(4);
        start_n = 1'b1;
        cy(20);
    endtask
    task lvl(input logic [3:0] n, input int s);
        chk({10'h000, done_int_n, 1'b0, fifo_level}, {10'h000, n == 4'h0,
            1'b0, n});
        chk(starts[15:0] - s0[15:0], s[15:0]);
    endtask
    task tally_and_finish;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        cy(20000);
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        cy(5);
        reset = 1'b0;
        cy(2);
        s0 = 0;
        chk({4'h0, config_register}, 16'h0000);
        lvl(4'h0, 0);
        xfer({4'hA, 12'h56A});
        chk({4'h0, config_register}, 16'h056A);
        xfer(16'h9000);
        chk({4'h0, r[11:0]}, 16'h056A);
        lvl(4'h0, 0);
        repeat (4) xfer(16'h0000);
        lvl(4'h4, 4);
        cs_n = 1'b0;
        cy(4);
        chk({15'h0000, serial_out_oe}, 16'h0001);
        frame(16'h0000);
        chk({15'h0000, serial_out_oe}, 16'h0000);
        cs_n = 1'b1;
        cy(8);
        chk({12'h000, r[15:12]}, 16'h000B);
        chk({12'h000, fifo_level}, 16'h0004);
        cs_n = 1'b0;
        cy(4);
        for (int k = 0; k < 4; k++) begin
            frame(16'hE000);
            chk({6'h00, r[15:6]}, {6'h00, 7'h5A, k[1:0], 1'b0});
            chk({15'h0000, serial_out_oe}, (k < 3) ? 16'h0001 : 16'h0000);
            cy(6);
        end
        cs_n = 1'b1;
        cy(8);
        xfer(16'h0000);
        lvl(4'h0, 4);
        $display("sweep test done");
        lat = 4'hC;
        xfer({4'hA, 12'h0F7});
        s0 = starts;
        cs_n = 1'b0;
        pin();
        cs_n = 1'b1;
        cy(8);
        lvl(4'h0, 0);
        repeat (2) pin();
        lvl(4'h2, 2);
        cs_n = 1'b0;
        cy(4);
        for (int k = 0; k < 2; k++) begin
            frame(16'hE000);
            chk({6'h00, r[15:6]}, {6'h00, 7'h5A, 2'h0, k[0]});
        end
        cy(4);
        cs_n = 1'b1;
        cy(8);
        repeat (2) pin();
        lvl(4'h2, 4);
        chk({13'h0000, conv_channel}, 16'h0001);
        xfer({4'hA, 12'h008});
        lvl(4'h0, 4);
        $display("repeat sweep test done");
        lat = 4'h4;
        xfer({4'hA, 12'h031});
        s0 = starts;
        repeat (2) xfer(16'h2000);
        lvl(4'h2, 2);
        chk({13'h0000, conv_channel}, 16'h0002);
        xfer({4'hA, 12'h008});
        chk({12'h000, fifo_level}, 16'h0000);
        $display("repeat test done");
        xfer(16'h3000);
        chk({12'h000, fifo_level}, 16'h0001);
        chk({13'h0000, conv_channel}, 16'h0003);
        chk({15'h0000, done_int_n}, 16'h0001);
        xfer({4'hA, 12'h00C});
        s0 = starts;
        xfer(16'h5000);
        lvl(4'h0, 0);
        pin();
        chk(starts[15:0] - s0[15:0], 16'h0001);
        chk({13'h0000, conv_channel}, 16'h0005);
        $display("single shot test done");
        tally_and_finish();
    end
endmodule

// [rtl/asq_defs.vh]
// constants for the serial converter sequencer
// assumes a 50 MHz ref_clk and a 16-clock serial frame
`ifndef ASQ_DEFS_VH
`define ASQ_DEFS_VH

// frame and command layout
`define ASQ_FRAME_BITS 5'h10
`define ASQ_CMD_BITS 5'h04
`define ASQ_CMD_RD_CFG 4'h9
`define ASQ_CMD_WR_CFG 4'hA
`define ASQ_CMD_RD_FIFO 4'hE
`define ASQ_CMD_SEL_TOP 4'h8

// config register fields
`define ASQ_CFG_W 12
`define ASQ_CFG_RESET 12'h000
`define ASQ_CFG_MODE_LO 0
`define ASQ_CFG_EXT 2
`define ASQ_CFG_EOC_SEL 3
`define ASQ_CFG_THR_LO 4
`define ASQ_CFG_SEQ_LO 6

// conversion modes
`define ASQ_MODE_SINGLE 2'h0
`define ASQ_MODE_REPEAT 2'h1
`define ASQ_MODE_SWEEP 2'h2
`define ASQ_MODE_RSWEEP 2'h3

// fifo
`define ASQ_FIFO_DEPTH 4'h8
`define ASQ_THR_FULL 4'h8
`define ASQ_THR_3Q 4'h6
`define ASQ_THR_HALF 4'h4
`define ASQ_THR_1Q 4'h2
`define ASQ_DATA_W 10

`endif

// [rtl/asq_sequencer.v]
// serial command decode, conversion sequencing and result fifo
// assumes an analog core that answers conv_start with one conv_done pulse
//
// What this block does
// - mode 10 converts each sequence channel once
// - normal sweep starts conversion at command decode
// - sweep raises one interrupt at fifo threshold
// - mode 11 repeats the channel sequence
// - extended sampling starts on start pin, cs high
// - eoc only in mode 00, else interrupt
// - read config decodes in 4 clocks, then shifts
// - first frame after a threshold interrupt presents fifo head
// - wrong command stops output, keeps the entry
// - read cycles start no conversion, no interrupt
// - each fifo result takes 16 serial clocks
// - write cycle loads 12 config bits
// - config write starts nothing, raises nothing
// - single-shot extended converts on start pin rise
// - mode 01 repeats one selected channel
// - config write clears the fifo
// - eight entry fifo, programmable threshold
`include "asq_defs.vh"

module asq_sequencer (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // serial pins
    input wire cs_n,
    input wire frame_sync,
    input wire sclk,
    input wire serial_in,
    output wire serial_out,
    output wire serial_out_oe,
    input wire sample_start_pin_n,
    output wire done_int_n,
    // analog core
    output wire conv_start,
    output wire [2:0] conv_channel,
    input wire conv_done,
    input wire [`ASQ_DATA_W-1:0] conv_data,
    // status
    output wire [`ASQ_CFG_W-1:0] config_register,
    output wire [3:0] fifo_level
);

    // all pins pass two flops before use
    reg [4:0] sync1_ff;
    reg [4:0] sync2_ff;
    reg [4:0] sync3_ff;
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync1_ff <= 5'h1F;
            sync2_ff <= 5'h1F;
            sync3_ff <= 5'h1F;
        end else begin
            sync1_ff <= {cs_n, frame_sync, sclk, serial_in,
                         sample_start_pin_n};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    wire cs_n_s = sync2_ff[4];
    wire sin_s = sync2_ff[1];
    wire cs_fall = sync3_ff[4] & ~sync2_ff[4];
    wire fs_rise = ~sync3_ff[3] & sync2_ff[3];
    wire sclk_rise = ~sync3_ff[2] & sync2_ff[2];
    wire start_rise = ~sync3_ff[0] & sync2_ff[0];
    wire frame_start = cs_fall | (fs_rise & ~cs_n_s);

    reg [`ASQ_CFG_W-1:0] cfg_ff;
    wire [1:0] mode = cfg_ff[`ASQ_CFG_MODE_LO+1:`ASQ_CFG_MODE_LO];
    wire ext_mode = cfg_ff[`ASQ_CFG_EXT];
    wire eoc_sel = cfg_ff[`ASQ_CFG_EOC_SEL];
    wire fifo_mode = (mode != `ASQ_MODE_SINGLE);

    reg [3:0] thr;
    always @* begin
        case (cfg_ff[`ASQ_CFG_THR_LO+1:`ASQ_CFG_THR_LO])
            2'h0: thr = `ASQ_THR_FULL;
            2'h1: thr = `ASQ_THR_3Q;
            2'h2: thr = `ASQ_THR_HALF;
            default: thr = `ASQ_THR_1Q;
        endcase
    end

    // sweep sequences as a table of channel patterns
    function [2:0] seq_chan;
        input [1:0] sel;
        input [2:0] idx;
        begin
            case (sel)
                2'h0: seq_chan = idx;
                2'h1: seq_chan = {idx[1:0], 1'b0};
                2'h2: seq_chan = {idx[2:1], 1'b0};
                default: seq_chan = {1'b0, idx[1:0]};
            endcase
        end
    endfunction

    // serial frame state
    reg active_ff;
    reg [4:0] bit_cnt_ff;
    reg [15:0] rx_ff;
    reg [15:0] tx_ff;
    reg out_ff;
    reg oe_ff;
    reg reading_ff;
    reg conv_pend_ff;

    // conversion and fifo state
    reg [`ASQ_DATA_W-1:0] fifo_mem [0:7];
    reg [2:0] wr_ptr_ff;
    reg [2:0] rd_ptr_ff;
    reg [3:0] count_ff;
    reg busy_ff;
    reg start_ff;
    reg [2:0] chan_ff;
    reg [2:0] sel_chan_ff;
    reg [2:0] seq_idx_ff;
    reg sweep_done_ff;
    reg int_raised_ff;
    reg int_ff;
    reg after_int_ff;
    reg ext_arm_ff;

    wire [15:0] rx_next = {rx_ff[14:0], sin_s};
    wire decode_now = active_ff & sclk_rise &
        (bit_cnt_ff == `ASQ_CMD_BITS - 5'h01);
    wire frame_end = active_ff & sclk_rise &
        (bit_cnt_ff == `ASQ_FRAME_BITS - 5'h01);
    wire [3:0] cmd = rx_next[3:0];
    wire cmd_is_rw = (cmd == `ASQ_CMD_RD_CFG) |
        (cmd == `ASQ_CMD_WR_CFG) | (cmd == `ASQ_CMD_RD_FIFO);
    wire wr_cfg = frame_end & (rx_next[15:12] == `ASQ_CMD_WR_CFG);
    wire head_word = (count_ff != 4'h0);
    wire [15:0] head_tx = {fifo_mem[rd_ptr_ff], 6'h00};

    // room to convert: not busy, fifo not full, not parked at threshold
    wire can_conv = ~busy_ff & (count_ff != `ASQ_FIFO_DEPTH) &
        ~int_raised_ff & ~sweep_done_ff;

    // normal sampling fires at decode once the command is not a read/write
    wire norm_go = decode_now & conv_pend_ff & ~cmd_is_rw;
    wire ext_go = ext_mode & start_rise & cs_n_s & ~busy_ff &
        ((mode == `ASQ_MODE_SINGLE) ? ext_arm_ff : can_conv);
    wire go = norm_go | ext_go;
    wire pop = frame_end & reading_ff;
    wire push = conv_done & busy_ff & (count_ff != `ASQ_FIFO_DEPTH);

    // interrupt event: mode 00 after each conversion, else at threshold
    wire next_count_hits = fifo_mode & ~int_raised_ff &
        ((count_ff + {3'h0, push} - {3'h0, pop}) >= thr);
    wire set_int = (push & (mode == `ASQ_MODE_SINGLE)) |
        next_count_hits;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            active_ff <= 1'b0;
            bit_cnt_ff <= 5'h00;
            rx_ff <= 16'h0000;
            tx_ff <= 16'h0000;
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
            reading_ff <= 1'b0;
            conv_pend_ff <= 1'b0;
            cfg_ff <= `ASQ_CFG_RESET;
            after_int_ff <= 1'b0;
            sel_chan_ff <= 3'h0;
            ext_arm_ff <= 1'b0;
        end else begin
            if (cs_n_s) begin
                active_ff <= 1'b0;
                oe_ff <= 1'b0;
                reading_ff <= 1'b0;
                conv_pend_ff <= 1'b0;
            end else if (frame_start) begin
                active_ff <= 1'b1;
                bit_cnt_ff <= 5'h00;
                // conversion is due unless the command proves a read/write
                conv_pend_ff <= ~ext_mode &
                    ((mode == `ASQ_MODE_SINGLE) | can_conv);
                if (fifo_mode & after_int_ff & head_word) begin
                    tx_ff <= head_tx;
                    out_ff <= head_tx[15];
                    oe_ff <= 1'b1;
                    reading_ff <= 1'b1;
                end else begin
                    tx_ff <= 16'h0000;
                    out_ff <= 1'b0;
                    oe_ff <= 1'b0;
                    reading_ff <= 1'b0;
                end
            end else if (active_ff & sclk_rise) begin
                rx_ff <= rx_next;
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
                tx_ff <= {tx_ff[14:0], 1'b0};
                out_ff <= tx_ff[14];
                if (decode_now) begin
                    conv_pend_ff <= 1'b0;
                    if (cmd == `ASQ_CMD_RD_CFG) begin
                        tx_ff <= {cfg_ff, 4'h0};
                        // a config read must not pop the shown head entry
                        reading_ff <= 1'b0;
                        out_ff <= cfg_ff[`ASQ_CFG_W-1];
                        oe_ff <= 1'b1;
                    end else if (cmd == `ASQ_CMD_RD_FIFO) begin
                        after_int_ff <= 1'b0;
                        if (~reading_ff & head_word) begin
                            reading_ff <= 1'b1;
                            oe_ff <= 1'b1;
                        end
                    end else if (reading_ff) begin
                        // entry stays in the fifo for a later read
                        reading_ff <= 1'b0;
                        oe_ff <= 1'b0;
                    end
                    if (cmd < `ASQ_CMD_SEL_TOP)
                        sel_chan_ff <= cmd[2:0];
                    if (ext_mode & (mode == `ASQ_MODE_SINGLE) & ~cmd_is_rw)
                        ext_arm_ff <= 1'b1;
                end
                if (frame_end) begin
                    // the next frame begins with no new chip select
                    bit_cnt_ff <= 5'h00;
                    if (wr_cfg)
                        cfg_ff <= rx_next[`ASQ_CFG_W-1:0];
                    if (reading_ff & (count_ff > 4'h1)) begin
                        tx_ff <= {fifo_mem[rd_ptr_ff + 3'h1], 6'h00};
                        out_ff <= fifo_mem[rd_ptr_ff + 3'h1][`ASQ_DATA_W-1];
                    end else begin
                        reading_ff <= 1'b0;
                        oe_ff <= 1'b0;
                    end
                end
            end
            if (ext_go)
                ext_arm_ff <= 1'b0;
            if (set_int & fifo_mode)
                after_int_ff <= 1'b1;
        end
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_ff <= 3'h0;
            rd_ptr_ff <= 3'h0;
            count_ff <= 4'h0;
            busy_ff <= 1'b0;
            start_ff <= 1'b0;
            chan_ff <= 3'h0;
            seq_idx_ff <= 3'h0;
            sweep_done_ff <= 1'b0;
            int_raised_ff <= 1'b0;
            int_ff <= 1'b0;
        end else begin
            start_ff <= go;
            if (go) begin
                busy_ff <= 1'b1;
                if ((mode == `ASQ_MODE_SWEEP) | (mode == `ASQ_MODE_RSWEEP)) begin
                    chan_ff <= seq_chan(cfg_ff[`ASQ_CFG_SEQ_LO+1:
                                               `ASQ_CFG_SEQ_LO],
                                        seq_idx_ff);
                    seq_idx_ff <= seq_idx_ff + 3'h1;
                    if (mode == `ASQ_MODE_SWEEP &
                        ({1'b0, seq_idx_ff} + 4'h1 >= thr))
                        sweep_done_ff <= 1'b1;
                end else if (norm_go & (cmd < `ASQ_CMD_SEL_TOP)) begin
                    // the select in this very frame names the channel
                    chan_ff <= cmd[2:0];
                end else begin
                    chan_ff <= sel_chan_ff;
                end
            end else if (conv_done) begin
                busy_ff <= 1'b0;
            end
            if (push) begin
                fifo_mem[wr_ptr_ff] <= conv_data;
                wr_ptr_ff <= wr_ptr_ff + 3'h1;
            end
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + 3'h1;
            count_ff <= count_ff + {3'h0, push} - {3'h0, pop};
            if (set_int & fifo_mode)
                int_raised_ff <= 1'b1;
            else if (fifo_mode & pop & (count_ff == 4'h1)) begin
                // drained: repeat modes resume, sweep waits for config
                int_raised_ff <= 1'b0;
                if (mode == `ASQ_MODE_RSWEEP)
                    seq_idx_ff <= 3'h0;
            end
            // a new event wins over the clear at frame start
            if (set_int)
                int_ff <= 1'b1;
            else if (frame_start)
                int_ff <= 1'b0;
            if (wr_cfg) begin
                wr_ptr_ff <= 3'h0;
                rd_ptr_ff <= 3'h0;
                count_ff <= 4'h0;
                seq_idx_ff <= 3'h0;
                sweep_done_ff <= 1'b0;
                int_raised_ff <= 1'b0;
            end
        end
    end

    // eoc is high when idle, low while converting; int is active low
    reg pin_ff;
    always @(posedge ref_clk or posedge reset) begin
        if (reset)
            pin_ff <= 1'b1;
        else if ((mode == `ASQ_MODE_SINGLE) & eoc_sel)
            pin_ff <= ~busy_ff & ~go;
        else
            pin_ff <= ~(set_int | (int_ff & ~frame_start));
    end

    assign serial_out = out_ff;
    assign serial_out_oe = oe_ff;
    assign done_int_n = pin_ff;
    assign conv_start = start_ff;
    assign conv_channel = chan_ff;
    assign config_register = cfg_ff;
    assign fifo_level = count_ff;

endmodule
